//--- hdl/pfc_pkg.sv
/*
  Package for the port function configuration block: register offsets,
  reset values, field positions and sizes.
  Assumes an APB slave with 32-bit data and word-aligned registers.
*/
package pfc_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_PINS = 32;
  localparam int NUM_IRQ = 6;
  localparam int SEL_W = 5;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_ANALOG = 12'h000;
  localparam logic [11:0] OFS_DIR = 12'h004;
  localparam logic [11:0] OFS_LATCH = 12'h008;
  localparam logic [11:0] OFS_OPEN_DRAIN = 12'h00C;
  localparam logic [11:0] OFS_PIN_LEVEL = 12'h010;
  localparam logic [11:0] OFS_LCD_MODE = 12'h014;
  localparam logic [11:0] OFS_LCD_INPUT = 12'h018;
  localparam logic [11:0] OFS_DEBUG_STOP = 12'h01C;
  localparam logic [11:0] OFS_RESET_MASK = 12'h020;
  localparam logic [11:0] OFS_RISE = 12'h024;
  localparam logic [11:0] OFS_FALL = 12'h028;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h02C;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h030;
  localparam logic [11:0] OFS_SEL_BASE = 12'h040;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_ANALOG = 32'h0000_00FF;
  localparam logic [31:0] RST_DIR = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_SWD_DISABLE = 0;
  localparam int BIT_RESET_MASK = 0;
  localparam int BIT_CAP_SCHMITT = 0;
  localparam int BIT_LCD_SCHMITT = 1;
  localparam int PIN_SWDIO = 13;
  localparam int PIN_SWCLK = 14;
  localparam int PIN_RESET = 16;
  localparam int PIN_MAIN_OSC0 = 17;
  localparam int PIN_MAIN_OSC1 = 18;
  localparam int PIN_SUB_OSC0 = 19;
  localparam int PIN_SUB_OSC1 = 20;
  localparam int PIN_CAP0 = 8;
  localparam int PIN_CAP1 = 9;
  localparam int PIN_LCD0 = 10;
  localparam int PIN_LCD3 = 12;
  localparam int PIN_LCD_IN0 = 21;
endpackage

//--- hdl/pfc_edge_detect.sv
/*
  One external-interrupt channel: pin selection and edge detection.
  Assumes the gated pin levels are synchronous to pclk.
*/
`timescale 1ns/1ns
module pfc_edge_detect #(
  parameter int NPINS = 32,
  parameter int SW = 5
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Pin levels and configuration
  input wire logic [NPINS-1:0] pin_in,
  input wire logic [SW-1:0] ext_irq_pin_select,
  input wire logic rise_en,
  input wire logic fall_en,
  // Event
  output logic edge_event
);
  logic prev;
  logic cur;

  // Selected pin level
  assign cur = pin_in[ext_irq_pin_select];

  // Previous level of the selected pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= 1'b0;
    end else if (clk_en) begin
      prev <= cur;
    end
  end

  // Edge pulse by enable
  assign edge_event = clk_en & ((rise_en & cur & ~prev) | (fall_en & ~cur & prev));
endmodule

//--- hdl/pfc_top.sv
/*
  Port function configuration: analog/digital select, direction, output
  latch, debug/reset/oscillator masking, LCD assignment, input gating and
  six external-interrupt channels, behind an APB slave.
  Assumes pin inputs synchronous to pclk and pads outside resolving enables.
*/
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ns
module pfc_top #(
  parameter int NPINS = pfc_pkg::NUM_PINS,
  parameter int NIRQ = pfc_pkg::NUM_IRQ
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic [NPINS-1:0] pin_in,
  output logic [NPINS-1:0] pin_out,
  output logic [NPINS-1:0] pin_oe,
  output logic [NPINS-1:0] pin_pullup,
  output logic [NPINS-1:0] pin_analog,
  output logic [NPINS-1:0] pin_lcd,
  // Clock-generator status
  input wire logic main_crystal_osc_on,
  input wire logic main_ext_clk_on,
  input wire logic sub_crystal_osc_on,
  input wire logic sub_ext_clk_on,
  // System outputs
  output logic ext_reset_n,
  output logic swd_enable,
  output logic [NIRQ-1:0] ext_irq_event,
  output logic irq
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [NPINS-1:0] pin_analog_select;
  logic [NPINS-1:0] pin_direction;
  logic [NPINS-1:0] out_latch;
  logic [NPINS-1:0] open_drain;
  logic [NPINS-1:0] lcd_segment_port_mode;
  logic [1:0] lcd_pin_input_control;
  logic serial_debug_disable;
  logic reset_pin_mask;
  logic [NIRQ-1:0] rising_edge_enable_reg;
  logic [NIRQ-1:0] falling_edge_enable_reg;
  logic [NIRQ-1:0] irq_status;
  logic [NIRQ-1:0] irq_mask;
  logic [pfc_pkg::SEL_W-1:0] ext_irq_pin_select [NIRQ];
  logic [NPINS-1:0] pin_level;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wr;
  logic rd;
  logic sel_hit;
  logic mapped;
  logic [NPINS-1:0] in_ok;
  logic [NPINS-1:0] gpio_ok;
  logic [NPINS-1:0] gated_in;
  logic [NIRQ-1:0] edge_ev;
  logic [31:0] next_rdata;

  // Write and read strobes in the access phase
  assign wr = psel & penable & pwrite & clk_en;
  assign rd = psel & penable & ~pwrite & clk_en;
  assign pready = 1'b1;
  assign sel_hit = (paddr >= pfc_pkg::OFS_SEL_BASE) &&
                   (paddr < pfc_pkg::OFS_SEL_BASE + 12'(4 * NIRQ));

  // Address match helper
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a[11:2] == ofs[11:2]);
  endfunction

  // Config registers writable by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_analog_select <= NPINS'(pfc_pkg::RST_ANALOG);
      pin_direction <= NPINS'(pfc_pkg::RST_DIR);
      out_latch <= NPINS'(pfc_pkg::RST_ZERO);
      open_drain <= NPINS'(pfc_pkg::RST_ZERO);
      lcd_segment_port_mode <= NPINS'(pfc_pkg::RST_ZERO);
      lcd_pin_input_control <= 2'h0;
      serial_debug_disable <= 1'b0;
      reset_pin_mask <= 1'b0;
      rising_edge_enable_reg <= NIRQ'(pfc_pkg::RST_ZERO);
      falling_edge_enable_reg <= NIRQ'(pfc_pkg::RST_ZERO);
      irq_mask <= NIRQ'(pfc_pkg::RST_ZERO);
    end else if (wr) begin
      if (hit(paddr, pfc_pkg::OFS_ANALOG)) pin_analog_select <= pwdata[NPINS-1:0];
      if (hit(paddr, pfc_pkg::OFS_DIR)) pin_direction <= pwdata[NPINS-1:0];
      if (hit(paddr, pfc_pkg::OFS_LATCH)) out_latch <= pwdata[NPINS-1:0];
      if (hit(paddr, pfc_pkg::OFS_OPEN_DRAIN)) open_drain <= pwdata[NPINS-1:0];
      if (hit(paddr, pfc_pkg::OFS_LCD_MODE)) lcd_segment_port_mode <= pwdata[NPINS-1:0];
      if (hit(paddr, pfc_pkg::OFS_LCD_INPUT)) lcd_pin_input_control <= pwdata[1:0];
      if (hit(paddr, pfc_pkg::OFS_DEBUG_STOP)) begin
        serial_debug_disable <= pwdata[pfc_pkg::BIT_SWD_DISABLE];
      end
      if (hit(paddr, pfc_pkg::OFS_RESET_MASK)) begin
        reset_pin_mask <= pwdata[pfc_pkg::BIT_RESET_MASK];
      end
      if (hit(paddr, pfc_pkg::OFS_RISE)) rising_edge_enable_reg <= pwdata[NIRQ-1:0];
      if (hit(paddr, pfc_pkg::OFS_FALL)) falling_edge_enable_reg <= pwdata[NIRQ-1:0];
      if (hit(paddr, pfc_pkg::OFS_IRQ_MASK)) irq_mask <= pwdata[NIRQ-1:0];
    end
  end

  // Per-channel pin select registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NIRQ; i++) ext_irq_pin_select[i] <= '0;
    end else if (wr && sel_hit) begin
      ext_irq_pin_select[paddr[4:2]] <= pwdata[pfc_pkg::SEL_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Pin function
  // ----------------------------------------------------------------
  // Pins that may act as GPIO given debug, reset and oscillator states
  always_comb begin
    gpio_ok = '1;
    gpio_ok[pfc_pkg::PIN_SWDIO] = serial_debug_disable;
    gpio_ok[pfc_pkg::PIN_SWCLK] = serial_debug_disable;
    gpio_ok[pfc_pkg::PIN_RESET] = reset_pin_mask;
    gpio_ok[pfc_pkg::PIN_MAIN_OSC0] = ~(main_crystal_osc_on | main_ext_clk_on);
    gpio_ok[pfc_pkg::PIN_MAIN_OSC1] = ~(main_crystal_osc_on | main_ext_clk_on);
    gpio_ok[pfc_pkg::PIN_SUB_OSC0] = ~(sub_crystal_osc_on | sub_ext_clk_on);
    gpio_ok[pfc_pkg::PIN_SUB_OSC1] = ~(sub_crystal_osc_on | sub_ext_clk_on);
  end

  // Input buffer enables, LCD-shared pins gated by Schmitt bits
  always_comb begin
    in_ok = '1;
    in_ok[pfc_pkg::PIN_CAP0] = lcd_pin_input_control[pfc_pkg::BIT_CAP_SCHMITT];
    in_ok[pfc_pkg::PIN_CAP1] = lcd_pin_input_control[pfc_pkg::BIT_CAP_SCHMITT];
    for (int k = pfc_pkg::PIN_LCD0; k <= pfc_pkg::PIN_LCD3; k++) begin
      in_ok[k] = lcd_pin_input_control[pfc_pkg::BIT_LCD_SCHMITT];
    end
    in_ok[pfc_pkg::PIN_LCD_IN0] = lcd_pin_input_control[pfc_pkg::BIT_LCD_SCHMITT];
  end

  // Gated digital input
  assign gated_in = pin_in & ~pin_analog_select & in_ok & gpio_ok;
  assign pin_analog = pin_analog_select;
  assign pin_lcd = ~pin_analog_select & lcd_segment_port_mode;

  // Output drivers, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= '0;
      pin_oe <= '0;
      pin_pullup <= '0;
      pin_level <= '0;
    end else if (clk_en) begin
      for (int p = 0; p < NPINS; p++) begin
        pin_out[p] <= out_latch[p];
        pin_oe[p] <= gpio_ok[p] & ~pin_analog_select[p] & ~pin_direction[p] &
                     ~pin_lcd[p] & (~open_drain[p] | ~out_latch[p]);
      end
      pin_pullup <= '0;
      pin_pullup[pfc_pkg::PIN_SWDIO] <= ~serial_debug_disable;
      pin_pullup[pfc_pkg::PIN_SWCLK] <= ~serial_debug_disable;
      pin_level <= gated_in & pin_direction;
    end
  end

  // Reset and debug function outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_reset_n <= 1'b1;
      swd_enable <= 1'b1;
    end else if (clk_en) begin
      ext_reset_n <= reset_pin_mask | pin_in[pfc_pkg::PIN_RESET];
      swd_enable <= ~serial_debug_disable;
    end
  end

  // ----------------------------------------------------------------
  // External interrupt channels
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NIRQ; c++) begin : g_ch
    pfc_edge_detect #(
      .NPINS(NPINS),
      .SW(pfc_pkg::SEL_W)
    ) u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .pin_in(gated_in),
      .ext_irq_pin_select(ext_irq_pin_select[c]),
      .rise_en(rising_edge_enable_reg[c]),
      .fall_en(falling_edge_enable_reg[c]),
      .edge_event(edge_ev[c])
    );
  end

  // Sticky status; set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
    end else if (clk_en) begin
      if (wr && hit(paddr, pfc_pkg::OFS_IRQ_STATUS)) begin
        irq_status <= (irq_status & ~pwdata[NIRQ-1:0]) | edge_ev;
      end else begin
        irq_status <= irq_status | edge_ev;
      end
    end
  end

  assign ext_irq_event = edge_ev;
  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read mux
  always_comb begin
    next_rdata = '0;
    mapped = 1'b1;
    if (sel_hit) next_rdata[pfc_pkg::SEL_W-1:0] = ext_irq_pin_select[paddr[4:2]];
    else if (hit(paddr, pfc_pkg::OFS_ANALOG)) next_rdata[NPINS-1:0] = pin_analog_select;
    else if (hit(paddr, pfc_pkg::OFS_DIR)) next_rdata[NPINS-1:0] = pin_direction;
    else if (hit(paddr, pfc_pkg::OFS_LATCH)) next_rdata[NPINS-1:0] = out_latch;
    else if (hit(paddr, pfc_pkg::OFS_OPEN_DRAIN)) next_rdata[NPINS-1:0] = open_drain;
    else if (hit(paddr, pfc_pkg::OFS_PIN_LEVEL)) next_rdata[NPINS-1:0] = pin_level;
    else if (hit(paddr, pfc_pkg::OFS_LCD_MODE)) next_rdata[NPINS-1:0] = lcd_segment_port_mode;
    else if (hit(paddr, pfc_pkg::OFS_LCD_INPUT)) next_rdata[1:0] = lcd_pin_input_control;
    else if (hit(paddr, pfc_pkg::OFS_DEBUG_STOP)) next_rdata[0] = serial_debug_disable;
    else if (hit(paddr, pfc_pkg::OFS_RESET_MASK)) next_rdata[0] = reset_pin_mask;
    else if (hit(paddr, pfc_pkg::OFS_RISE)) next_rdata[NIRQ-1:0] = rising_edge_enable_reg;
    else if (hit(paddr, pfc_pkg::OFS_FALL)) next_rdata[NIRQ-1:0] = falling_edge_enable_reg;
    else if (hit(paddr, pfc_pkg::OFS_IRQ_STATUS)) next_rdata[NIRQ-1:0] = irq_status;
    else if (hit(paddr, pfc_pkg::OFS_IRQ_MASK)) next_rdata[NIRQ-1:0] = irq_mask;
    else mapped = 1'b0;
  end

  assign prdata = rd ? next_rdata : '0;
  assign pslverr = psel & penable & ~mapped;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_clear_analog(int p);
    wr && hit(paddr, pfc_pkg::OFS_ANALOG) && !pwdata[p];
  endsequence

  AST_ANALOG_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> pin_analog_select == NPINS'(pfc_pkg::RST_ANALOG))
    else $error("analog group not analog after reset");
  AST_ANALOG_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    s_clear_analog(0) |=> !pin_analog[0])
    else $error("analog select not cleared");
  AST_SWD_PULLUP: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !serial_debug_disable |-> !gated_in[pfc_pkg::PIN_SWDIO] ##1
      pin_pullup[pfc_pkg::PIN_SWDIO])
    else $error("debug pin not held");
  AST_OUT_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
    pin_oe[0] |-> !pin_analog_select[0] || $changed(pin_analog_select[0]))
    else $error("analog pin driven");
  AST_RESET_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !reset_pin_mask && !pin_in[pfc_pkg::PIN_RESET] |=> !ext_reset_n)
    else $error("reset pin ignored");
  AST_MAIN_OSC: assert property (@(posedge pclk) disable iff (!presetn)
    main_crystal_osc_on |-> !gated_in[pfc_pkg::PIN_MAIN_OSC0])
    else $error("oscillator pin used as gpio");
  AST_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && (edge_ev != '0) |=> (irq_status & $past(edge_ev)) == $past(edge_ev))
    else $error("edge event lost");
  AST_LCD_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    !lcd_pin_input_control[pfc_pkg::BIT_CAP_SCHMITT] |-> !gated_in[pfc_pkg::PIN_CAP0])
    else $error("lcd input not gated");
  AST_IRQ_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    irq == ((irq_status & irq_mask) != '0))
    else $error("irq mismatch");

  // Oscillator in use: pads must be released on the next edge
  sequence s_main_osc_busy;
    clk_en && (main_crystal_osc_on || main_ext_clk_on);
  endsequence

  sequence s_sub_osc_busy;
    clk_en && (sub_crystal_osc_on || sub_ext_clk_on);
  endsequence

  // Status clear with no competing event
  sequence s_status_clear;
    wr && hit(paddr, pfc_pkg::OFS_IRQ_STATUS) && (edge_ev == '0);
  endsequence

  AST_MAIN_OSC_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
    s_main_osc_busy |=> !pin_oe[pfc_pkg::PIN_MAIN_OSC0] && !pin_oe[pfc_pkg::PIN_MAIN_OSC1])
    else $error("main oscillator pin driven");
  AST_SUB_OSC: assert property (@(posedge pclk) disable iff (!presetn)
    s_sub_osc_busy |-> (!gated_in[pfc_pkg::PIN_SUB_OSC0] && !gated_in[pfc_pkg::PIN_SUB_OSC1])
      ##1 (!pin_oe[pfc_pkg::PIN_SUB_OSC0] && !pin_oe[pfc_pkg::PIN_SUB_OSC1]))
    else $error("sub oscillator pin used as gpio");
  AST_DIR_INPUT: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> (pin_oe & $past(pin_direction)) == '0)
    else $error("input pin driven");
  AST_LCD_NO_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en |=> (pin_oe & $past(pin_lcd)) == '0)
    else $error("lcd pin driven as gpio");
  AST_SCHMITT: assert property (@(posedge pclk) disable iff (!presetn)
    !lcd_pin_input_control[pfc_pkg::BIT_LCD_SCHMITT] |->
      gated_in[pfc_pkg::PIN_LCD3:pfc_pkg::PIN_LCD0] == '0)
    else $error("lcd input not gated");
  AST_W1C: assert property (@(posedge pclk) disable iff (!presetn)
    s_status_clear |=> (irq_status & $past(pwdata[NIRQ-1:0])) == '0)
    else $error("status not cleared");
  AST_ANALOG_IN: assert property (@(posedge pclk) disable iff (!presetn)
    (gated_in & pin_analog_select) == '0)
    else $error("analog pin reads digital");
endmodule

//--- verif/pfc_board.sv
/*
  Board model for the pin side: resolves each pad from the block's drive,
  its pull-up and an external source chosen by the bench.
  Assumes the bench changes ext_en and ext_val just after rising edges.
*/
`timescale 1ns/1ns
module pfc_board #(
  parameter int NPINS = 32
) (
  // Clock
  input wire logic pclk,
  // Block side
  input wire logic [NPINS-1:0] pin_out,
  input wire logic [NPINS-1:0] pin_oe,
  input wire logic [NPINS-1:0] pin_pullup,
  // External sources
  input wire logic [NPINS-1:0] ext_en,
  input wire logic [NPINS-1:0] ext_val,
  // Pad levels
  output logic [NPINS-1:0] pin_in
);
  logic [NPINS-1:0] float_pat = 32'h5555_5555;

  // Undriven pads wander every cycle
  always @(posedge pclk) float_pat <= ~pin_in;

  // Pad level: block drive, then external source, then pull-up
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
        pin_pullup[i] ? 1'b1 : float_pat[i];
    end
  end
endmodule

//--- verif/tb.sv
/*
  Bench for the port function block: APB master, board model and a
  reference model of the pin gating. Assumes the package pin map.
*/
`timescale 1ns/1ns
module tb;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
  logic main_crystal_osc_on, main_ext_clk_on, sub_crystal_osc_on, sub_ext_clk_on;
  logic ext_reset_n, swd_enable, irq;
  logic [5:0] ext_irq_event;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, pin_in, pin_out, pin_oe, pin_pullup;
  logic [31:0] pin_analog, pin_lcd, ext_en, ext_val, m_analog, m_dir, m_latch;
  logic [31:0] m_od, m_lcd, m_lcdin, m_dbg, m_reset_pin_mask;
  int bad_count, cmp_count;
  int ev_cnt[6] = '{default: 0};
  int ev_exp[6] = '{default: 0};

  pfc_top pfc_top_inst (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pin_pullup,
    .pin_analog, .pin_lcd, .main_crystal_osc_on, .main_ext_clk_on, .sub_crystal_osc_on,
    .sub_ext_clk_on, .ext_reset_n, .swd_enable, .ext_irq_event, .irq);
  pfc_board pfc_board_inst (.pclk, .pin_out, .pin_oe, .pin_pullup, .ext_en, .ext_val,
    .pin_in);

  // Clock
  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  // Count event pulses per channel
  always @(negedge pclk) begin
    for (int k = 0; k < 6; k++) begin
      if (ext_irq_event[k] === 1'b1) ev_cnt[k]++;
    end
  end

  // ----------------------------------------------------------------
  // Tasks and model
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      chk(0, 1, "bus timeout");
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    case (a)
      pfc_pkg::OFS_ANALOG: m_analog = d;
      pfc_pkg::OFS_DIR: m_dir = d;
      pfc_pkg::OFS_LATCH: m_latch = d;
      pfc_pkg::OFS_OPEN_DRAIN: m_od = d;
      pfc_pkg::OFS_LCD_MODE: m_lcd = d;
      pfc_pkg::OFS_LCD_INPUT: m_lcdin = d;
      pfc_pkg::OFS_DEBUG_STOP: m_dbg = d;
      pfc_pkg::OFS_RESET_MASK: m_reset_pin_mask = d;
      default: ;
    endcase
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e, "read");
  endtask

  // Digital pins free of debug, reset and oscillator use
  function automatic logic [31:0] gp();
    logic [31:0] g;
    g = ~m_analog;
    if (!m_dbg[0]) g[14:13] = 2'b00;
    if (!m_reset_pin_mask[0]) g[16] = 1'b0;
    if (main_crystal_osc_on | main_ext_clk_on) g[18:17] = 2'b00;
    if (sub_crystal_osc_on | sub_ext_clk_on) g[20:19] = 2'b00;
    return g;
  endfunction

  // Pins whose input buffer is on
  function automatic logic [31:0] inen();
    logic [31:0] g;
    g = 32'hFFFF_FFFF;
    if (!m_lcdin[0]) g[9:8] = 2'b00;
    if (!m_lcdin[1]) g = g & ~32'h0020_1C00;
    return g;
  endfunction

  task automatic check_pins();
    logic [31:0] g, lv, osc;
    repeat (2) @(posedge pclk);
    lv = gp();
    g = lv & ~m_lcd;
    osc = ~g & 32'h001E_0000 & ~m_lcd;
    chk(pin_analog, m_analog, "analog");
    chk(pin_lcd, ~m_analog & m_lcd, "lcd");
    chk(pin_oe & g, g & ~m_dir & ~(m_od & m_latch), "drive");
    chk(pin_out & g & ~m_dir, m_latch & g & ~m_dir, "latch");
    chk(pin_oe & osc, 32'h0000_0000, "osc pins");
    chk({29'h0, swd_enable, pin_pullup[14:13]}, {29'h0, {3{~m_dbg[0]}}}, "debug");
    apb(1'b0, pfc_pkg::OFS_PIN_LEVEL, 32'h0000_0000);
    chk(rd & ext_en, pin_in & ext_en & m_dir & lv & inen(), "level");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] ex, msk;
    int p;
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ext_en = 32'hFFFF_FFFF;
    ext_val = 32'hFFFF_FFFF;
    main_crystal_osc_on = 1'b0;
    main_ext_clk_on = 1'b0;
    sub_crystal_osc_on = 1'b0;
    sub_ext_clk_on = 1'b0;
    m_analog = pfc_pkg::RST_ANALOG;
    m_dir = pfc_pkg::RST_DIR;
    {m_latch, m_od, m_lcd, m_lcdin, m_dbg, m_reset_pin_mask} = {6{pfc_pkg::RST_ZERO}};
    void'($urandom(35314));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and default pin state
    rchk(pfc_pkg::OFS_ANALOG, pfc_pkg::RST_ANALOG);
    rchk(pfc_pkg::OFS_DIR, pfc_pkg::RST_DIR);
    for (int a = 8; a < 'h58; a += 4) begin
      if (a != 'h10 && (a < 'h34 || a >= 'h40)) rchk(12'(a), pfc_pkg::RST_ZERO);
    end
    check_pins();
    $display("Test reset done");
    // Unmapped place and frozen clock enable
    apb(1'b1, 12'h034, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h1, "slverr");
    rchk(12'h034, 32'h0000_0000);
    chk({31'h0, err}, 32'h1, "slverr");
    clk_en <= 1'b0;
    apb(1'b1, pfc_pkg::OFS_LATCH, 32'hFFFF_FFFF);
    clk_en <= 1'b1;
    rchk(pfc_pkg::OFS_LATCH, m_latch);
    $display("Test bus done");
    // Shared reset pin
    ext_val[16] <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, ext_reset_n}, 32'h0, "reset pin");
    wr(pfc_pkg::OFS_RESET_MASK, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk({31'h0, ext_reset_n}, 32'h1, "reset masked");
    $display("Test reset pin done");
    // Random pin configurations
    for (int i = 0; i < 8; i++) begin
      ext_val <= $urandom();
      ext_en <= $urandom();
      main_crystal_osc_on <= 1'($urandom_range(1));
      main_ext_clk_on <= 1'($urandom_range(1));
      sub_crystal_osc_on <= 1'($urandom_range(1));
      sub_ext_clk_on <= 1'($urandom_range(1));
      wr(pfc_pkg::OFS_LATCH, $urandom());
      wr(pfc_pkg::OFS_OPEN_DRAIN, $urandom());
      wr(pfc_pkg::OFS_DIR, $urandom());
      wr(pfc_pkg::OFS_ANALOG, $urandom() & 32'h0000_00FF);
      wr(pfc_pkg::OFS_LCD_MODE, $urandom() & $urandom());
      wr(pfc_pkg::OFS_LCD_INPUT, $urandom_range(3));
      wr(pfc_pkg::OFS_DEBUG_STOP, $urandom_range(1));
      check_pins();
    end
    $display("Test pins done");
    // Interrupt channels: every channel, every edge mode
    wr(pfc_pkg::OFS_DIR, pfc_pkg::RST_DIR);
    wr(pfc_pkg::OFS_LCD_MODE, 32'h0000_0000);
    wr(pfc_pkg::OFS_LCD_INPUT, 32'h0000_0000);
    wr(pfc_pkg::OFS_ANALOG, pfc_pkg::RST_ANALOG);
    ext_val <= 32'h0000_0000;
    ext_en <= 32'hFFFF_FFFF;
    for (int c = 0; c < 6; c++) begin
      for (int m = 1; m < 4; m++) begin
        p = 22 + $urandom_range(9);
        wr(pfc_pkg::OFS_SEL_BASE + 12'(4 * c), p);
        wr(pfc_pkg::OFS_RISE, 32'(m[0]) << c);
        wr(pfc_pkg::OFS_FALL, 32'(m[1]) << c);
        msk = (m == 3) ? 32'h0000_0000 : 32'h0000_0001 << c;
        wr(pfc_pkg::OFS_IRQ_MASK, msk);
        wr(pfc_pkg::OFS_IRQ_STATUS, 32'h0000_003F);
        for (int e = 1; e >= 0; e--) begin
          ext_val[p] <= 1'(e);
          repeat (4) @(posedge pclk);
          ex = 32'(e ? m[0] : m[1]) << c;
          ev_exp[c] += e ? m[0] : m[1];
          rchk(pfc_pkg::OFS_IRQ_STATUS, ex);
          chk({31'h0, irq}, {31'h0, |(ex & msk)}, "irq");
          wr(pfc_pkg::OFS_IRQ_STATUS, ex);
          @(posedge pclk);
          chk({31'h0, irq}, 32'h0, "irq cleared");
        end
      end
      chk(ev_cnt[c], ev_exp[c], "event pulses");
    end
    // Analog and unbuffered pins feed no event to channel 0
    wr(pfc_pkg::OFS_RISE, 32'h0000_0001);
    wr(pfc_pkg::OFS_FALL, 32'h0000_0001);
    for (int q = 0; q < 9; q += 8) begin
      wr(pfc_pkg::OFS_SEL_BASE, q);
      wr(pfc_pkg::OFS_IRQ_STATUS, 32'h0000_003F);
      ext_val[q] <= 1'b1;
      repeat (4) @(posedge pclk);
      rchk(pfc_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    end
    $display("Test interrupts done");
    end_sim();
  end
endmodule
